// ===== hdl/i2c_passthrough_addr_strap.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_pt_defs.svh"

module i2c_passthrough_addr_strap
   import i2c_pt_pkg::*;
#(
   parameter bit IS_DESER  = 1'b0,
   parameter int GPIO_W    = 4
) (
   // Clock, reset and enable
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              clkEn,
   // Quantized address straps
   input  wire logic [2:0]        addrStrapLow,
   input  wire logic [1:0]        addrStrapHigh,
   // Pass-through setting and covered remote targets
   input  wire logic              passThroughEn,
   input  wire logic [6:0]        remoteTarget,
   input  wire logic [6:0]        remoteTargetMask,
   // Local I2C pins
   input  wire logic              sclIn,
   output logic                   sclOut,
   output logic                   sclOe,
   input  wire logic              sdaIn,
   output logic                   sdaOut,
   output logic                   sdaOe,
   // Control channel towards the remote bus
   output logic                   fwdReq,
   output logic [7:0]             fwdByte,
   output logic                   fwdFirst,
   input  wire logic              fwdDone,
   input  wire logic              fwdAck,
   input  wire logic [7:0]        fwdRdByte,
   // GPIO
   input  wire logic [GPIO_W-1:0] gpioRemote,
   output logic [GPIO_W-1:0]      gpioOut,
   // Decoded own address
   output logic [6:0]             slaveAddr
);

   localparam int SKEW_CYC = `SYNC_SKEW_NS / `CLK_PERIOD_NS;
   localparam int NREG     = 1 << `REG_IDX_W;

   slvState_t             state_q;
   owner_t                owner_q;
   logic                  sclPrev_q, sdaPrev_q, strapDone_q, first_q, rd_q, ptrSet_q;
   logic [3:0]            bitCnt_q;
   logic [7:0]            shift_q, tx_q;
   logic [6:0]            addr_q;
   logic [`REG_IDX_W-1:0] ptr_q;
   logic [7:0]            regs_q [NREG];
   logic                  sclRise, sclFall, startCond, stopCond, isOwn, isRemote;

   // Pins are synchronous; edges come from one stage of history.
   assign sclRise   = sclIn & ~sclPrev_q;
   assign sclFall   = ~sclIn & sclPrev_q;
   assign startCond = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
   assign stopCond  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;
   assign isOwn     = (shift_q[7:1] == addr_q);
   // Only targets inside the covered set are relayed, so the rest of the far bus stays hidden.
   assign isRemote  = passThroughEn
                      & (((shift_q[7:1] ^ remoteTarget) & remoteTargetMask) == 7'h00)
                      & ~isOwn;
   assign slaveAddr = addr_q;
   assign sclOut    = 1'b0;
   assign sdaOut    = 1'b0;

   // Pin history; one sample per system clock is far finer than a fast-mode bit.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else if (clkEn) begin
         sclPrev_q <= sclIn;
         sdaPrev_q <= sdaIn;
      end
   end

   // Straps are caught once after reset release; later strap motion cannot move the address.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         strapDone_q <= 1'b0;
         addr_q      <= `SER_ADDR_BASE;
      end else if (clkEn && !strapDone_q) begin
         strapDone_q <= 1'b1;
         if (IS_DESER) begin
            addr_q <= `DES_ADDR_BASE + {3'h0, addrStrapHigh, 2'h0}
                      + {5'h00, addrStrapLow[1:0]};
         end else if (addrStrapLow > `SER_LEVEL_MAX) begin
            addr_q <= `SER_ADDR_BASE + {4'h0, `SER_LEVEL_MAX};
         end else begin
            addr_q <= `SER_ADDR_BASE + {4'h0, addrStrapLow};
         end
      end
   end

   // Byte sequencer: address match, ACK, stretching and data movement.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q  <= ST_IDLE;
         owner_q  <= OWN_NONE;
         bitCnt_q <= 4'h0;
         shift_q  <= 8'h00;
         tx_q     <= 8'h00;
         first_q  <= 1'b0;
         rd_q     <= 1'b0;
         sdaOe    <= 1'b0;
         sclOe    <= 1'b0;
         fwdReq   <= 1'b0;
         fwdByte  <= 8'h00;
         fwdFirst <= 1'b0;
      end else if (clkEn) begin
         fwdReq <= 1'b0;
         if (startCond || stopCond) begin
            state_q  <= startCond ? ST_SHIFT : ST_IDLE;
            owner_q  <= OWN_NONE;
            bitCnt_q <= 4'h0;
            first_q  <= startCond;
            sdaOe    <= 1'b0;
            sclOe    <= 1'b0;
         end else begin
            unique case (state_q)
               ST_IDLE: begin
               end
               ST_SHIFT: begin
                  if (sclRise) begin
                     shift_q  <= {shift_q[6:0], sdaIn};
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end else if (sclFall && bitCnt_q == `BYTE_DONE_CNT) begin
                     bitCnt_q <= 4'h0;
                     if (first_q) begin
                        rd_q <= shift_q[`RW_BIT];
                        if (isOwn) begin
                           owner_q <= OWN_LOCAL;
                           sdaOe   <= 1'b1;
                           state_q <= ST_ACK;
                        end else if (isRemote) begin
                           owner_q  <= OWN_REMOTE;
                           sclOe    <= 1'b1;
                           fwdReq   <= 1'b1;
                           fwdByte  <= shift_q;
                           fwdFirst <= 1'b1;
                           state_q  <= ST_WAIT;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else if (owner_q == OWN_REMOTE) begin
                        sclOe    <= 1'b1;
                        fwdReq   <= 1'b1;
                        fwdByte  <= shift_q;
                        fwdFirst <= 1'b0;
                        state_q  <= ST_WAIT;
                     end else begin
                        sdaOe   <= 1'b1;
                        state_q <= ST_ACK;
                     end
                     first_q <= 1'b0;
                  end
               end
               // SCL stays low until the far side answers; the master must tolerate it.
               ST_WAIT: begin
                  if (fwdDone) begin
                     sclOe   <= 1'b0;
                     sdaOe   <= fwdAck;
                     tx_q    <= fwdRdByte;
                     state_q <= ST_ACK;
                  end
               end
               ST_ACK: begin
                  if (sclFall) begin
                     if (rd_q) begin
                        tx_q    <= (owner_q == OWN_LOCAL) ? regs_q[ptr_q] : tx_q;
                        sdaOe   <= (owner_q == OWN_LOCAL) ? ~regs_q[ptr_q][7] : ~tx_q[7];
                        state_q <= ST_TX;
                     end else begin
                        sdaOe   <= 1'b0;
                        state_q <= ST_SHIFT;
                     end
                  end
               end
               ST_TX: begin
                  if (sclFall) begin
                     bitCnt_q <= bitCnt_q + 4'h1;
                     tx_q     <= {tx_q[6:0], 1'b0};
                     sdaOe    <= (bitCnt_q == `BYTE_LAST_BIT) ? 1'b0 : ~tx_q[6];
                     state_q  <= (bitCnt_q == `BYTE_LAST_BIT) ? ST_RACK : ST_TX;
                  end
               end
               ST_RACK: begin
                  if (sclRise) begin
                     bitCnt_q <= 4'h0;
                     state_q  <= sdaIn ? ST_IDLE : ST_ACK;
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Embedded slave registers: first written byte is the pointer, then data with auto-increment.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ptr_q    <= '0;
         ptrSet_q <= 1'b0;
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= 8'h00;
         end
      end else if (clkEn) begin
         if (startCond) begin
            ptrSet_q <= 1'b0;
         end else if (owner_q == OWN_LOCAL && sclFall && bitCnt_q == `BYTE_DONE_CNT
                      && state_q == ST_SHIFT && !rd_q) begin
            if (!ptrSet_q) begin
               ptr_q    <= shift_q[`REG_IDX_W-1:0];
               ptrSet_q <= 1'b1;
            end else begin
               regs_q[ptr_q] <= shift_q;
               ptr_q         <= ptr_q + 1'b1;
            end
         end else if (state_q == ST_RACK && sclRise && !sdaIn && owner_q == OWN_LOCAL) begin
            ptr_q <= ptr_q + 1'b1;
         end
      end
   end

   // GPIO: register bits or the forwarded remote level; one cycle of latency keeps skew bounded.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gpioOut <= '0;
      end else if (clkEn) begin
         gpioOut <= regs_q[0][`GPIO_SEL_BIT] ? gpioRemote : regs_q[0][GPIO_W-1:0];
      end
   end

   // Checks.
   sequence s_addrNine;
      state_q == ST_SHIFT && first_q && sclFall && bitCnt_q == `BYTE_DONE_CNT;
   endsequence

   sequence s_stretchHeld;
      sclOe && state_q == ST_WAIT;
   endsequence

   a_remote_stretch: assert property (@(posedge clk_sys) disable iff (rst || !clkEn)
      s_addrNine and (isRemote && !startCond && !stopCond) |=> s_stretchHeld and fwdReq)
      else $error("remote address did not stretch and request");
   a_stretch_release: assert property (@(posedge clk_sys) disable iff (rst)
      state_q == ST_WAIT && fwdDone && clkEn && !startCond && !stopCond |=> !sclOe)
      else $error("stretch not released after remote answer");
   a_own_not_fwd: assert property (@(posedge clk_sys) disable iff (rst)
      owner_q == OWN_LOCAL |-> !fwdReq && !sclOe)
      else $error("own transaction forwarded");
   a_disabled_local: assert property (@(posedge clk_sys) disable iff (rst)
      !passThroughEn && !$past(passThroughEn) |-> !fwdReq || !fwdFirst)
      else $error("forwarded while pass-through disabled");
   a_uncovered_blocked: assert property (@(posedge clk_sys) disable iff (rst)
      fwdReq && fwdFirst && $stable(remoteTarget) && $stable(remoteTargetMask)
      |-> ((fwdByte[7:1] ^ remoteTarget) & remoteTargetMask) == 7'h00)
      else $error("uncovered target forwarded");
   a_addr_held: assert property (@(posedge clk_sys) disable iff (rst)
      strapDone_q |=> $stable(addr_q))
      else $error("slave address changed after capture");
   a_ser_range: assert property (@(posedge clk_sys) disable iff (rst)
      strapDone_q && !IS_DESER |-> addr_q >= 7'h58 && addr_q <= 7'h5d)
      else $error("serializer address out of range");
   a_des_range: assert property (@(posedge clk_sys) disable iff (rst)
      strapDone_q && IS_DESER |-> addr_q[6:4] == 3'h6)
      else $error("deserializer address out of range");
   a_gpio_follow: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && regs_q[0][`GPIO_SEL_BIT] && SKEW_CYC > 1 |=> gpioOut == $past(gpioRemote))
      else $error("forwarded GPIO late");

endmodule : i2c_passthrough_addr_strap
`default_nettype wire

// ===== common/i2c_pt_defs.svh
`ifndef I2C_PT_DEFS_SVH
`define I2C_PT_DEFS_SVH

// Slave address construction from the strap levels.
`define SER_ADDR_BASE   7'h58
`define SER_LEVEL_MAX   3'h5
`define DES_ADDR_BASE   7'h60
`define DES_HIGH_SHIFT  2

// Bit positions within a byte and the byte length.
`define RW_BIT          0
`define BYTE_LAST_BIT   4'h7
`define BYTE_DONE_CNT   4'h8

// Local register file size and the GPIO source select bit in register 0.
`define REG_IDX_W       3
`define GPIO_SEL_BIT    7

// Timing: clock period and the forwarded GPIO skew limit.
`define CLK_PERIOD_NS   8
`define SYNC_SKEW_NS    25000
`define I2C_MAX_KBPS    400

`endif

// ===== common/i2c_pt_pkg.sv
package i2c_pt_pkg;

   // One-hot slave sequencer states.
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_SHIFT = 6'h02,
      ST_WAIT  = 6'h04,
      ST_ACK   = 6'h08,
      ST_TX    = 6'h10,
      ST_RACK  = 6'h20
   } slvState_t;

   // Who owns the current transaction.
   typedef enum logic [1:0] {
      OWN_NONE   = 2'h0,
      OWN_LOCAL  = 2'h1,
      OWN_REMOTE = 2'h2
   } owner_t;

endpackage : i2c_pt_pkg

// ===== bench/remote_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far end of the control channel: answers each forwarded byte after a set delay.
module remote_side_model (
   // Clock, reset and answer set-up
   input  wire logic       clk_sys, rst, nack,
   input  wire logic [7:0] dly, rdData,
   // Channel towards the block
   input  wire logic       fwdReq, fwdFirst,
   input  wire logic [7:0] fwdByte,
   output logic            fwdDone, fwdAck,
   output logic [7:0]      fwdRdByte, firstByte,
   output int              nReq
);
   logic [8:0] cnt_q;
   // One-cycle answer pulse after at least 256 cycles, so the master always meets a held SCL.
   always_ff @(posedge clk_sys) begin
      fwdDone <= !rst && cnt_q == 9'h001;
      cnt_q <= rst ? 9'h000 : fwdReq ? {1'b1, dly} : cnt_q - {8'h00, cnt_q != 9'h000};
      nReq <= rst ? 0 : nReq + int'(fwdReq);
      if (fwdReq && fwdFirst) begin
         firstByte <= fwdByte;
      end
   end
   // Between answers the lines show the inverse, so an early or late sample reads wrong.
   assign fwdAck    = fwdDone ? ~nack : nack;
   assign fwdRdByte = fwdDone ? rdData : ~rdData;
endmodule : remote_side_model
`default_nettype wire

// ===== bench/tb_i2c_passthrough_addr_strap.sv
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_passthrough_addr_strap;
   localparam int Q = 105; // Three of these make one bit, just under 400 kbps.
   localparam logic [7:0] ADDR [6] = '{8'ha0, 8'ha0, 8'ha2, 8'ha2, 8'ha0, 8'ha1};
   localparam logic [5:0] PE = 6'b111101, M7E = 6'b001000, NK = 6'b010000, FWD = 6'b111001;
   logic        clk_sys, rst, clkEn, passThroughEn, mScl, mSda, nack, stretched, k;
   logic [2:0]  addrStrapLow;
   logic [1:0]  addrStrapHigh;
   logic [3:0]  gpioRemote, gpioOut, m;
   logic [6:0]  remoteTarget, remoteTargetMask, addrS, addrD;
   logic [7:0]  dly, rdData, fwdByte, fwdRdByte, firstByte, r, v;
   logic        sclOe, sdaOe, fwdReq, fwdFirst, fwdDone, fwdAck;
   logic [31:0] rnd;
   int          n_mismatch = 0, num_checks = 0, cyc = 0, nReq, n0;
   // Open-drain wires: low when either party pulls.
   wire logic   sclIn = mScl & ~sclOe;
   wire logic   sdaIn = mSda & ~sdaOe;

   i2c_passthrough_addr_strap i2c_passthrough_addr_strap_i (
      .clk_sys, .rst, .clkEn, .addrStrapLow, .addrStrapHigh, .passThroughEn, .remoteTarget,
      .remoteTargetMask, .sclIn, .sclOut(), .sclOe, .sdaIn, .sdaOut(), .sdaOe, .fwdReq, .fwdByte,
      .fwdFirst, .fwdDone, .fwdAck, .fwdRdByte, .gpioRemote, .gpioOut, .slaveAddr(addrS));
   // Second build only for its address decode; its bus side stays idle.
   i2c_passthrough_addr_strap #(.IS_DESER(1'b1)) i2c_passthrough_addr_strap_des_i (
      .clk_sys, .rst, .clkEn, .addrStrapLow, .addrStrapHigh, .passThroughEn, .remoteTarget,
      .remoteTargetMask, .sclIn(1'b1), .sclOut(), .sclOe(), .sdaIn(1'b1), .sdaOut(), .sdaOe(),
      .fwdReq(), .fwdByte(), .fwdFirst(), .fwdDone(1'b0), .fwdAck, .fwdRdByte, .gpioRemote,
      .gpioOut(), .slaveAddr(addrD));
   remote_side_model remote_side_model_i (.clk_sys, .rst, .nack, .dly, .rdData, .fwdReq, .fwdFirst,
      .fwdByte, .fwdDone, .fwdAck, .fwdRdByte, .firstByte, .nReq);

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // A hung handshake ends the run as a failure.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [7:0] serExp(input logic [2:0] l);
      return (l > 3'h5) ? 8'h5d : 8'h58 + {5'h00, l};
   endfunction : serExp
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Release SCL and wait, bounded, while the block holds it low.
   task automatic sclUp();
      int w = 0;
      mScl <= 1'b1;
      tick(2);
      while (sclIn !== 1'b1 && w < 4000) begin
         stretched = 1'b1;
         w++;
         tick(1);
      end
      tick(Q);
   endtask : sclUp
   task automatic bitIo(input logic b, output logic s);
      mSda <= b;
      tick(Q);
      sclUp();
      s = sdaIn;
      mScl <= 1'b0;
      tick(Q);
   endtask : bitIo
   // Start when st is high, stop otherwise; a stop leaves SCL released.
   task automatic cond(input logic st);
      mSda <= st;
      tick(Q);
      sclUp();
      mSda <= ~st;
      tick(Q);
      mScl <= ~st;
      tick(Q);
   endtask : cond
   // Byte sent MSB first; the master always releases SDA in the ninth bit.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitIo(tx[i], s);
         rx[i] = s;
      end
      bitIo(1'b1, s);
      ack = ~s;
   endtask : xfer

   initial begin
      rst = 1'b1;
      clkEn = 1'b1;
      {addrStrapLow, addrStrapHigh, passThroughEn, nack, mScl, mSda} = 9'h003;
      {remoteTarget, remoteTargetMask, dly, rdData, gpioRemote} = {7'h50, 7'h7f, 20'h20000};
      rnd = 32'h66b704a6;
      tick(10);
      // Every strap code; the last leaves the serializer at 0x5a.
      for (int i = 0; i < 16; i++) begin
         m = i[3:0] + 4'h3;
         addrStrapLow <= m[2:0];
         addrStrapHigh <= m[3:2];
         rst <= 1'b1;
         tick(2);
         rst <= 1'b0;
         tick(3);
         chk("serializer address", serExp(m[2:0]), {1'b0, addrS});
         chk("deserializer address", 8'h60 + {4'h0, m}, {1'b0, addrD});
         rnd = lfsr(rnd);
         addrStrapLow <= rnd[2:0];
         addrStrapHigh <= rnd[4:3];
         tick(3);
         chk("held address", serExp(m[2:0]), {1'b0, addrS});
      end
      // With the enable low the straps wait; the first enabled edge catches them.
      clkEn <= 1'b0;
      addrStrapLow <= 3'h2;
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(3);
      chk("frozen address", 8'h58, {1'b0, addrS});
      clkEn <= 1'b1;
      tick(3);
      chk("thawed address", serExp(3'h2), {1'b0, addrS});
      // Own address also covered by forwarding: still served locally.
      passThroughEn <= 1'b1;
      remoteTarget <= 7'h5a;
      for (int j = 0; j < 2; j++) begin
         rnd = lfsr(rnd);
         v = j ? 8'h80 : {4'h0, rnd[3:0]};
         n0 = nReq;
         cond(1'b1);
         xfer(8'hb4, r, k);
         chk("own address ack", 8'h01, {7'h0, k});
         xfer(8'h00, r, k);
         xfer(v, r, k);
         cond(1'b1);
         xfer(8'hb4, r, k);
         xfer(8'h00, r, k);
         cond(1'b1);
         xfer(8'hb5, r, k);
         xfer(8'hff, r, k);
         cond(1'b0);
         chk("register readback", v, r);
         chk("local forward count", 8'h00, 8'(nReq - n0));
         gpioRemote <= rnd[7:4];
         tick(3);
         chk("gpio level", {4'h0, j ? rnd[7:4] : rnd[3:0]}, {4'h0, gpioOut});
      end
      // Enable, mask and remote answer cases against target 0x50.
      remoteTarget <= 7'h50;
      for (int c = 0; c < 6; c++) begin
         rnd = lfsr(rnd);
         passThroughEn <= PE[c];
         remoteTargetMask <= M7E[c] ? 7'h7e : 7'h7f;
         nack <= NK[c];
         dly <= rnd[7:0];
         rdData <= rnd[15:8];
         stretched = 1'b0;
         n0 = nReq;
         cond(1'b1);
         xfer(ADDR[c], r, k);
         if (k) xfer(ADDR[c][0] ? 8'hff : rnd[23:16], r, v[0]);
         cond(1'b0);
         chk("address ack", {7'h0, FWD[c] & ~NK[c]}, {7'h0, k});
         chk("forward count", {7'h0, FWD[c]} + {7'h0, FWD[c] & ~NK[c] & ~ADDR[c][0]},
             8'(nReq - n0));
         if (FWD[c]) chk("forwarded address", ADDR[c], firstByte);
         if (FWD[c]) chk("clock stretch", 8'h01, {7'h0, stretched});
         if (c == 5) chk("remote read", rnd[15:8], r);
      end
      test_done();
   end
endmodule : tb_i2c_passthrough_addr_strap
`default_nettype wire
